// ==== logic/tad_pkg.sv ====
/*
  tad_pkg: register offsets, field positions, reset values, states and
  carrier types for the tap and autosleep detector.
  assumes: registers are 8 bits wide, addressed by an 8-bit offset.
*/
package tad_pkg;
  localparam logic [7:0] OFS_TAP_THRESHOLD    = 8'h1D;
  localparam logic [7:0] OFS_TAP_LENGTH_LIMIT = 8'h21;
  localparam logic [7:0] OFS_TAP_LATENCY_TIME = 8'h22;
  localparam logic [7:0] OFS_SECOND_TAP_WIN   = 8'h23;
  localparam logic [7:0] OFS_TAP_AXIS_CONTROL = 8'h2A;
  localparam logic [7:0] OFS_EVENT_SRC_STATUS = 8'h2B;
  localparam logic [7:0] OFS_DATA_RATE_CTRL   = 8'h2C;
  localparam logic [7:0] OFS_IRQ_ENABLE       = 8'h2E;
  localparam logic [7:0] OFS_IRQ_SOURCE       = 8'h30;
  localparam logic [7:0] RST_REG              = 8'h00;
  // tap axis control fields
  localparam int AXC_IMPROVED = 4;
  localparam int AXC_SUPPRESS = 3;
  localparam int AXC_X        = 2;
  localparam int AXC_Y        = 1;
  localparam int AXC_Z        = 0;
  // irq enable and irq source fields
  localparam int IRQ_SINGLE   = 6;
  localparam int IRQ_DOUBLE   = 5;
  localparam int IRQ_ACTIVITY = 4;
  localparam int IRQ_INACTIVE = 3;
  // event source status fields
  localparam int EVS_ASLEEP   = 3;
  localparam int EVS_TAP_X    = 2;
  localparam int EVS_TAP_Z    = 0;
  // threshold scale: one threshold step is sixteen sample steps
  localparam int THR_SHIFT    = 4;

  typedef enum logic [2:0] {
    TAD_IDLE = 3'b000,
    TAD_TAP1 = 3'b001,
    TAD_LAT  = 3'b010,
    TAD_WIN  = 3'b011,
    TAD_TAP2 = 3'b100,
    TAD_WAIT = 3'b101
  } tad_state_t;

  typedef struct packed {
    logic signed [15:0] x;
    logic signed [15:0] y;
    logic signed [15:0] z;
  } tad_axes_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tad_reg_req_t;
endpackage : tad_pkg

// ==== logic/tad_detector.sv ====
/*
  tad_detector: single/double tap detection and link-mode autosleep.
  assumes: raw samples arrive at the undecimated rate with a strobe,
  filtered samples at the output rate with a strobe; activity and
  inactivity detection happen outside and arrive as one-cycle pulses.
*/
`timescale 1ns/10ps
module tad_detector (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              ce,
  input  wire tad_pkg::tad_reg_req_t reg_req,
  output logic [7:0]             reg_rdata,
  input  wire logic              raw_valid,
  input  wire tad_pkg::tad_axes_t raw_sample,
  input  wire logic              filt_valid,
  input  wire tad_pkg::tad_axes_t filt_sample,
  input  wire logic              activity_det,
  input  wire logic              inactivity_det,
  input  wire logic              sleep_en,
  input  wire logic              auto_sleep_en,
  input  wire logic              link_en,
  output logic                   low_rate,
  output logic [2:0]             tap_sign,
  output logic [7:0]             output_sample_rate
);
  logic [7:0]          thr_r;
  logic [7:0]          dur_r;
  logic [7:0]          lat_r;
  logic [7:0]          win_r;
  logic [7:0]          axc_r;
  logic [7:0]          rate_r;
  logic [7:0]          ien_r;
  logic [7:0]          src_r;
  logic [7:0]          src_nxt;
  logic [2:0]          first_r;
  logic [2:0]          cand_r;
  logic [2:0]          sign_r;
  logic [2:0]          csign_r;
  logic                asleep_r;
  logic                arm_act_r;
  logic [7:0]          rdata_r;
  logic [7:0]          cnt_r;
  logic [7:0]          cnt_inc;
  tad_pkg::tad_state_t st_r;
  tad_pkg::tad_axes_t  prev_r;
  tad_pkg::tad_axes_t  cur;
  logic                tick;
  logic                improved;
  logic [2:0]          ax_over;
  logic [2:0]          ax_first;
  logic                over;
  logic                dt_mode;
  logic                fire_single;
  logic                fire_double;
  logic                clr_src;
  logic                act_ev;
  logic                inact_ev;
  logic                sleep_combo;

  function automatic logic [15:0] mag(input logic signed [15:0] v);
    mag = v[15] ? 16'(-v) : 16'(v);
  endfunction : mag

  function automatic logic signed [15:0] dif(input logic signed [15:0] a,
                                            input logic signed [15:0] b);
    dif = 16'(a - b);
  endfunction : dif

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = reg_req.wr && (reg_req.addr == ofs);
  endfunction : wr_at

  // ac-coupled difference of filtered data in improved mode
  assign improved = axc_r[tad_pkg::AXC_IMPROVED];
  assign cur.x = improved ? dif(filt_sample.x, prev_r.x) : raw_sample.x;
  assign cur.y = improved ? dif(filt_sample.y, prev_r.y) : raw_sample.y;
  assign cur.z = improved ? dif(filt_sample.z, prev_r.z) : raw_sample.z;
  // one timer step per detection sample
  assign tick = improved ? filt_valid : raw_valid;

  assign ax_over[2] = axc_r[tad_pkg::AXC_X] &&
    (mag(cur.x) > (16'(thr_r) << tad_pkg::THR_SHIFT));
  assign ax_over[1] = axc_r[tad_pkg::AXC_Y] &&
    (mag(cur.y) > (16'(thr_r) << tad_pkg::THR_SHIFT));
  assign ax_over[0] = axc_r[tad_pkg::AXC_Z] &&
    (mag(cur.z) > (16'(thr_r) << tad_pkg::THR_SHIFT));
  assign over = |ax_over;
  assign ax_first = ax_over[2] ? 3'b100 : (ax_over[1] ? 3'b010 : ax_over);
  assign cnt_inc = cnt_r + 8'h01;

  // double tap only with nonzero latency and window
  assign dt_mode = ien_r[tad_pkg::IRQ_DOUBLE] && (lat_r != 8'h00) &&
                   (win_r != 8'h00);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prev_r <= '0;
    end else if (ce && filt_valid) begin
      prev_r <= filt_sample;
    end
  end

  // tap sequencer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r    <= tad_pkg::TAD_IDLE;
      cnt_r   <= 8'h00;
      cand_r  <= 3'h0;
      csign_r <= 3'h0;
    end else if (ce && tick) begin
      unique case (st_r)
        tad_pkg::TAD_IDLE: begin
          if (over) begin
            st_r    <= tad_pkg::TAD_TAP1;
            cnt_r   <= 8'h01;
            cand_r  <= ax_first;
            // sign bit set for negative acceleration
            csign_r <= {cur.x[15], cur.y[15], cur.z[15]};
          end
        end
        tad_pkg::TAD_TAP1: begin
          if (over) begin
            if (cnt_r >= dur_r) begin
              st_r <= tad_pkg::TAD_WAIT;
            end else begin
              cnt_r <= cnt_inc;
            end
          end else if (dt_mode) begin
            st_r  <= tad_pkg::TAD_LAT;
            cnt_r <= 8'h00;
          end else begin
            st_r <= tad_pkg::TAD_IDLE;
          end
        end
        tad_pkg::TAD_LAT: begin
          if (over && axc_r[tad_pkg::AXC_SUPPRESS]) begin
            st_r <= tad_pkg::TAD_WAIT;
          end else if (cnt_inc >= lat_r) begin
            st_r  <= over ? tad_pkg::TAD_WAIT : tad_pkg::TAD_WIN;
            cnt_r <= 8'h00;
          end else begin
            cnt_r <= cnt_inc;
          end
        end
        tad_pkg::TAD_WIN: begin
          // second tap must begin inside window
          if (over) begin
            st_r  <= tad_pkg::TAD_TAP2;
            cnt_r <= 8'h01;
          end else if (cnt_inc >= win_r) begin
            st_r <= tad_pkg::TAD_IDLE;
          end else begin
            cnt_r <= cnt_inc;
          end
        end
        tad_pkg::TAD_TAP2: begin
          if (over) begin
            // overlong second tap ends at limit
            if (cnt_r >= dur_r) begin
              st_r <= tad_pkg::TAD_WAIT;
            end else begin
              cnt_r <= cnt_inc;
            end
          end else begin
            st_r <= tad_pkg::TAD_IDLE;
          end
        end
        tad_pkg::TAD_WAIT: begin
          if (!over) begin
            st_r <= tad_pkg::TAD_IDLE;
          end
        end
        default: begin
          st_r <= tad_pkg::TAD_IDLE;
        end
      endcase
    end
  end

  // single-only fires at fall below threshold
  // with double armed, single fires on the verdict
  always_comb begin
    fire_single = 1'b0;
    fire_double = 1'b0;
    if (ce && tick) begin
      unique case (st_r)
        tad_pkg::TAD_TAP1: fire_single = !over && !dt_mode;
        tad_pkg::TAD_LAT: fire_single = (over &&
          axc_r[tad_pkg::AXC_SUPPRESS]) || ((cnt_inc >= lat_r) && over);
        tad_pkg::TAD_WIN: fire_single = !over && (cnt_inc >= win_r);
        tad_pkg::TAD_TAP2: begin
          fire_single = !over || (cnt_r >= dur_r);
          fire_double = !over;
        end
        default: begin
          fire_single = 1'b0;
          fire_double = 1'b0;
        end
      endcase
    end
  end

  // first axis latched on tap interrupt, never cleared
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      first_r <= 3'h0;
      sign_r  <= 3'h0;
    end else if (ce && fire_single) begin
      first_r <= cand_r;
      sign_r  <= csign_r;
    end
  end

  // link mode: activity only after inactivity
  assign act_ev   = activity_det && (!link_en || arm_act_r);
  assign inact_ev = inactivity_det && (!link_en || !arm_act_r);
  assign sleep_combo = sleep_en && auto_sleep_en && link_en;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      asleep_r  <= 1'b0;
      arm_act_r <= 1'b0;
    end else if (ce) begin
      if (act_ev) begin
        asleep_r  <= 1'b0;
        arm_act_r <= 1'b0;
      end else if (inact_ev) begin
        arm_act_r <= 1'b1;
        // enter low rate unless activity still pending
        if (sleep_combo && !src_r[tad_pkg::IRQ_ACTIVITY]) begin
          asleep_r <= 1'b1;
        end
      end
    end
  end

  // reading the source clears it; a new set wins
  assign clr_src = reg_req.rd && (reg_req.addr == tad_pkg::OFS_IRQ_SOURCE);
  always_comb begin
    src_nxt = clr_src ? 8'h00 : src_r;
    // each tap interrupt behind its own enable
    if (fire_single && ien_r[tad_pkg::IRQ_SINGLE]) begin
      src_nxt[tad_pkg::IRQ_SINGLE] = 1'b1;
    end
    if (fire_double && ien_r[tad_pkg::IRQ_DOUBLE]) begin
      src_nxt[tad_pkg::IRQ_DOUBLE] = 1'b1;
    end
    if (act_ev && ien_r[tad_pkg::IRQ_ACTIVITY]) begin
      src_nxt[tad_pkg::IRQ_ACTIVITY] = 1'b1;
    end
    if (inact_ev && ien_r[tad_pkg::IRQ_INACTIVE]) begin
      src_nxt[tad_pkg::IRQ_INACTIVE] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      src_r <= tad_pkg::RST_REG;
    end else if (ce) begin
      src_r <= src_nxt;
    end
  end

  // writable registers
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      thr_r  <= tad_pkg::RST_REG;
      dur_r  <= tad_pkg::RST_REG;
      lat_r  <= tad_pkg::RST_REG;
      win_r  <= tad_pkg::RST_REG;
      axc_r  <= tad_pkg::RST_REG;
      rate_r <= tad_pkg::RST_REG;
      ien_r  <= tad_pkg::RST_REG;
    end else if (ce) begin
      if (wr_at(tad_pkg::OFS_TAP_THRESHOLD)) thr_r <= reg_req.wdata;
      if (wr_at(tad_pkg::OFS_TAP_LENGTH_LIMIT)) dur_r <= reg_req.wdata;
      if (wr_at(tad_pkg::OFS_TAP_LATENCY_TIME)) lat_r <= reg_req.wdata;
      if (wr_at(tad_pkg::OFS_SECOND_TAP_WIN)) win_r <= reg_req.wdata;
      if (wr_at(tad_pkg::OFS_TAP_AXIS_CONTROL)) axc_r <= reg_req.wdata;
      if (wr_at(tad_pkg::OFS_DATA_RATE_CTRL)) rate_r <= reg_req.wdata;
      if (wr_at(tad_pkg::OFS_IRQ_ENABLE)) ien_r <= reg_req.wdata;
    end
  end

  // read data, registered one cycle after the read strobe
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_r <= 8'h00;
    end else if (ce && reg_req.rd) begin
      unique case (reg_req.addr)
        tad_pkg::OFS_TAP_THRESHOLD:    rdata_r <= thr_r;
        tad_pkg::OFS_TAP_LENGTH_LIMIT: rdata_r <= dur_r;
        tad_pkg::OFS_TAP_LATENCY_TIME: rdata_r <= lat_r;
        tad_pkg::OFS_SECOND_TAP_WIN:   rdata_r <= win_r;
        tad_pkg::OFS_TAP_AXIS_CONTROL: rdata_r <= axc_r;
        // asleep bit beside first tap axis
        tad_pkg::OFS_EVENT_SRC_STATUS: rdata_r <= {4'h0, asleep_r, first_r};
        tad_pkg::OFS_DATA_RATE_CTRL:   rdata_r <= rate_r;
        tad_pkg::OFS_IRQ_ENABLE:       rdata_r <= ien_r;
        tad_pkg::OFS_IRQ_SOURCE:       rdata_r <= src_r;
        default:                       rdata_r <= 8'h00;
      endcase
    end
  end

  assign reg_rdata          = rdata_r;
  assign low_rate           = asleep_r;
  assign tap_sign           = sign_r;
  assign output_sample_rate = rate_r;

  a_idle_to_tap: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_IDLE && over
    |=> st_r == tad_pkg::TAD_TAP1)
    else $error("tap start not taken");
  a_tap_too_long: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_TAP1 && over && cnt_r >= dur_r
    |=> st_r == tad_pkg::TAD_WAIT)
    else $error("overlong tap accepted");
  a_latency_holds: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_LAT && !over && cnt_inc < lat_r
    |=> st_r == tad_pkg::TAD_LAT && cnt_r == $past(cnt_inc))
    else $error("latency ended early");
  a_window_tap2: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_WIN && over
    |=> st_r == tad_pkg::TAD_TAP2 && cnt_r == 8'h01)
    else $error("second tap missed");
  a_single_only: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_TAP1 && !over && !dt_mode &&
    ien_r[tad_pkg::IRQ_SINGLE] |=> src_r[tad_pkg::IRQ_SINGLE])
    else $error("single tap not raised");
  a_single_defer: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_TAP1 && !over && dt_mode
    |-> !fire_single ##1 st_r == tad_pkg::TAD_LAT)
    else $error("single tap not deferred");
  a_suppress_lat: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_LAT && over &&
    axc_r[tad_pkg::AXC_SUPPRESS] |=> st_r == tad_pkg::TAD_WAIT)
    else $error("suppress ignored");
  a_tap2_long: assert property (@(posedge clk_sys) disable iff (reset)
    ce && tick && st_r == tad_pkg::TAD_TAP2 && over && cnt_r >= dur_r
    |-> !fire_double ##1 st_r == tad_pkg::TAD_WAIT)
    else $error("overlong second tap accepted");
  a_double_gate: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(src_r[tad_pkg::IRQ_DOUBLE]) |-> $past(dt_mode))
    else $error("double tap raised while disabled");
  a_sleep_entry: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(asleep_r) |-> $past(sleep_combo && inactivity_det))
    else $error("sleep entered without cause");
  a_wake_exit: assert property (@(posedge clk_sys) disable iff (reset)
    ce && act_ev |=> !low_rate && !arm_act_r)
    else $error("activity did not wake");
endmodule : tad_detector

// ==== test/tad_host.sv ====
/*
  tad_host: host model on the register side; one register access per
  call, strobes held for one clock and driven just after the edge.
  assumes: read data is registered and valid one cycle after read.
*/
`timescale 1ns/10ps
module tad_host (
  input  logic                  clk_sys,
  output tad_pkg::tad_reg_req_t reg_req,
  input  logic [7:0]            reg_rdata
);
  initial reg_req = '0;

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) #2;
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys) #2;
    reg_req.wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys) #2;
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys) #2;
    reg_req.rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : tad_host

// ==== test/tad_detector_test.sv ====
/*
  tad_detector_test: directed bench for tap detection and link sleep.
  assumes: samples every fourth clock, detection pulses from the bench.
*/
`timescale 1ns/10ps
module tad_detector_test;
  logic                  clk_sys, reset, ce, raw_valid, filt_valid;
  logic                  activity_det, inactivity_det, low_rate;
  logic                  sleep_en, auto_sleep_en, link_en;
  tad_pkg::tad_reg_req_t reg_req;
  tad_pkg::tad_axes_t    raw_sample, filt_sample;
  logic [7:0]            reg_rdata, output_sample_rate, v;
  logic [2:0]            tap_sign;
  int                    err_count, checks;

  tad_detector tad_detector_inst (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .raw_valid(raw_valid),
    .raw_sample(raw_sample), .filt_valid(filt_valid),
    .filt_sample(filt_sample), .activity_det(activity_det),
    .inactivity_det(inactivity_det), .sleep_en(sleep_en),
    .auto_sleep_en(auto_sleep_en), .link_en(link_en),
    .low_rate(low_rate), .tap_sign(tap_sign),
    .output_sample_rate(output_sample_rate));
  tad_host tad_host_inst (
    .clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    tad_host_inst.rd(a, v);
    chk(v, exp);
  endtask : rdchk

  // n samples of one value on the raw or filtered stream
  task automatic smp(input bit f, input logic [15:0] x, y, z,
                     input int n);
    repeat (n) begin
      @(posedge clk_sys) #2;
      if (f) filt_sample = {x, y, z};
      else raw_sample = {x, y, z};
      filt_valid = f;
      raw_valid = !f;
      @(posedge clk_sys) #2;
      raw_valid = 1'b0;
      filt_valid = 1'b0;
      repeat (2) @(posedge clk_sys);
    end
  endtask : smp

  task automatic cfg(input logic [7:0] axc, lat, en);
    tad_host_inst.wr(tad_pkg::OFS_TAP_THRESHOLD, 8'h31);
    tad_host_inst.wr(tad_pkg::OFS_TAP_LENGTH_LIMIT, 8'h11);
    tad_host_inst.wr(tad_pkg::OFS_TAP_LATENCY_TIME, lat);
    tad_host_inst.wr(tad_pkg::OFS_SECOND_TAP_WIN, 8'h41);
    tad_host_inst.wr(tad_pkg::OFS_TAP_AXIS_CONTROL, axc);
    tad_host_inst.wr(tad_pkg::OFS_IRQ_ENABLE, en);
  endtask : cfg

  // x tap of n samples, pause, optional second tap, then quiet
  task automatic tap(input int n, gap, m);
    smp(0, 16'hFC00, 0, 0, n);
    smp(0, 0, 0, 0, gap);
    smp(0, 16'hFC00, 0, 0, m);
    smp(0, 0, 0, 0, 90);
  endtask : tap

  task automatic t_regs;
    tad_host_inst.wr(tad_pkg::OFS_DATA_RATE_CTRL, 8'h0A);
    rdchk(tad_pkg::OFS_DATA_RATE_CTRL, 8'h0A);
    chk(output_sample_rate, 8'h0A);
    tad_host_inst.wr(tad_pkg::OFS_EVENT_SRC_STATUS, 8'hFF);
    rdchk(tad_pkg::OFS_EVENT_SRC_STATUS, 8'h00);
    rdchk(8'h3F, 8'h00);
    rdchk(tad_pkg::OFS_TAP_THRESHOLD, 8'h00);
  endtask : t_regs

  task automatic t_single;
    cfg(8'h04, 8'h11, 8'h40);
    smp(0, 0, 0, 16'hFC00, 3);
    smp(1, 0, 16'h0400, 0, 1);
    smp(1, 0, 0, 0, 30);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h00);
    tap(3, 0, 0);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h40);
    rdchk(tad_pkg::OFS_EVENT_SRC_STATUS, 8'h04);
    chk({5'h00, tap_sign}, 8'h04);
    tap(20, 0, 0);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h00);
    cfg(8'h04, 8'h00, 8'h60);
    tap(3, 0, 0);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h40);
  endtask : t_single

  task automatic t_double(input logic [7:0] en, exp);
    cfg(8'h04, 8'h11, en);
    tap(2, 22, 2);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, exp);
  endtask : t_double

  task automatic t_invalid;
    cfg(8'h0C, 8'h11, 8'h60);
    tap(2, 5, 1);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h40);
    cfg(8'h04, 8'h11, 8'h60);
    tap(1, 1, 25);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h40);
    tap(2, 22, 30);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h40);
  endtask : t_invalid

  task automatic t_improved;
    cfg(8'h12, 8'h11, 8'h40);
    smp(0, 0, 16'hFC00, 0, 3);
    smp(0, 0, 0, 0, 30);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h00);
    smp(1, 0, 16'h0400, 0, 1);
    smp(1, 0, 16'h0400, 0, 30);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h40);
    rdchk(tad_pkg::OFS_EVENT_SRC_STATUS, 8'h02);
    chk({7'h00, tap_sign[1]}, 8'h00);
  endtask : t_improved

  task automatic pulse(input bit act);
    @(posedge clk_sys) #2;
    activity_det = act;
    inactivity_det = !act;
    @(posedge clk_sys) #2;
    activity_det = 1'b0;
    inactivity_det = 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : pulse

  task automatic t_link;
    tad_host_inst.wr(tad_pkg::OFS_IRQ_ENABLE, 8'h18);
    sleep_en = 1'b1;
    auto_sleep_en = 1'b1;
    link_en = 1'b1;
    pulse(0);
    chk({7'h00, low_rate}, 8'h01);
    rdchk(tad_pkg::OFS_EVENT_SRC_STATUS, 8'h0A);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h08);
    pulse(0);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h00);
    pulse(1);
    chk({7'h00, low_rate}, 8'h00);
    pulse(0);
    chk({7'h00, low_rate}, 8'h00);
    tad_host_inst.rd(tad_pkg::OFS_IRQ_SOURCE, v);
    chk(v & 8'h10, 8'h10);
    pulse(1);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h10);
    pulse(1);
    rdchk(tad_pkg::OFS_IRQ_SOURCE, 8'h00);
    pulse(0);
    chk({7'h00, low_rate}, 8'h01);
  endtask : t_link

  initial begin
    err_count = 0;
    checks = 0;
    reset = 1'b1;
    ce = 1'b1;
    raw_valid = 1'b0;
    filt_valid = 1'b0;
    raw_sample = '0;
    filt_sample = '0;
    activity_det = 1'b0;
    inactivity_det = 1'b0;
    sleep_en = 1'b0;
    auto_sleep_en = 1'b0;
    link_en = 1'b0;
    repeat (12) @(posedge clk_sys);
    #2 reset = 1'b0;
    t_regs();
    t_single();
    t_double(8'h20, 8'h20);
    t_double(8'h60, 8'h60);
    t_invalid();
    t_improved();
    t_link();
    test_done();
  end
endmodule : tad_detector_test
